/* csp_cfg.svh */
// Constants of the clock source, start-up and prescaler block
`ifndef CSP_CFG_SVH
`define CSP_CFG_SVH

`define CSP_MCLK_HZ            250000000
`define CSP_WDT_OSC_HZ         128000
`define CSP_DELAY_SHORT_MS     4
`define CSP_DELAY_LONG_MS      64
`define CSP_CK_RESET_TAIL      14
`define CSP_CK_PD_INTERNAL     6
`define CSP_CK_XTAL_FAST       258
`define CSP_CK_XTAL_MID        1024
`define CSP_CK_XTAL_SLOW       16384
`define CSP_CHANGE_WINDOW      4

`define CSP_SRC_EXTERNAL       4'h0
`define CSP_SRC_RC_4MHZ        4'h2
`define CSP_SRC_RC_8MHZ        4'h4
`define CSP_SRC_LP_128KHZ      4'h6
`define CSP_SRC_XTAL_BIT       3
`define CSP_SUT_RESET_CODE     2'h2

`define CSP_DIV_CHANGE_BIT     7
`define CSP_DIV_CHANGE_WORD    8'h80
`define CSP_DIV_MAX_CODE       4'h8
`define CSP_DIV_RESET_CODE     4'h0
`define CSP_DIV_BY8_CODE       4'h3
`define CSP_TRIM_RESERVED_BIT  7

`endif

/* csp_pkg.sv */
// Types of the clock source, start-up and prescaler block
package csp_pkg;
    typedef enum logic [5:0] {
        CSP_ST_START = 6'h01,
        CSP_ST_OSC   = 6'h02,
        CSP_ST_RESET = 6'h04,
        CSP_ST_TAIL  = 6'h08,
        CSP_ST_RUN   = 6'h10,
        CSP_ST_SLEEP = 6'h20
    } csp_state_t;

    typedef enum logic [2:0] {
        CSP_SOURCE_EXTERNAL = 3'h0,
        CSP_SOURCE_RC4      = 3'h1,
        CSP_SOURCE_RC8      = 3'h2,
        CSP_SOURCE_LP128    = 3'h3,
        CSP_SOURCE_CRYSTAL  = 3'h4,
        CSP_SOURCE_RESERVED = 3'h7
    } csp_source_t;

    typedef enum logic [1:0] {
        CSP_RDELAY_NONE  = 2'h0,
        CSP_RDELAY_SHORT = 2'h1,
        CSP_RDELAY_LONG  = 2'h2
    } csp_rdelay_t;
endpackage

/* csp_divider.sv */
// Glitch-free power-of-two system clock divider
`timescale 1ns/1ps
`include "csp_cfg.svh"
module csp_divider #(
    parameter int FSEL_W = 4,
    parameter int CNT_W  = 8
) (
    input  wire logic              mclk,           // Undivided source clock
    input  wire logic              rst_n,          // Asynchronous reset, active low
    input  wire logic              runEnable,      // Divider may issue ticks
    input  wire logic              loadDefault,    // Load start-up factor
    input  wire logic [FSEL_W-1:0] defaultFactor,  // Start-up factor code
    input  wire logic              newFactorValid, // Accepted factor write
    input  wire logic [FSEL_W-1:0] newFactor,      // Factor code written
    output logic                   tick,           // One-cycle divided clock enable
    output logic [FSEL_W-1:0]      activeFactor    // Factor now in force
);
    logic [CNT_W-1:0]  count;
    logic              pending;
    logic [FSEL_W-1:0] pendingFactor;
    logic [CNT_W:0]    wideMask;
    logic [CNT_W-1:0]  mask;
    logic              switchNow;

    // Tick when the low bits of the free counter are all ones
    assign wideMask  = ({{CNT_W{1'b0}}, 1'b1} << activeFactor) - {{CNT_W{1'b0}}, 1'b1};
    assign mask      = wideMask[CNT_W-1:0];
    assign tick      = runEnable && ((count & mask) == mask);           // [R12]
    assign switchNow = tick && pending;

    // Free counter on the undivided clock; its state is never exported  [R14]
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            count <= {CNT_W{1'b0}};
        end else if (loadDefault || switchNow) begin
            count <= {CNT_W{1'b0}};                                      // [R15]
        end else if (runEnable) begin
            count <= count + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end

    // New factor waits for the end of the old period, so no short pulse  [R13]
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            activeFactor  <= `CSP_DIV_RESET_CODE;
            pending       <= 1'b0;
            pendingFactor <= `CSP_DIV_RESET_CODE;
        end else if (loadDefault) begin
            activeFactor <= defaultFactor;
            pending      <= 1'b0;
        end else begin
            if (switchNow) begin
                activeFactor <= pendingFactor;                           // [R15]
            end
            // A fresh write stays pending while an older one switches in
            if (newFactorValid) begin
                pending       <= 1'b1;
                pendingFactor <= newFactor;
            end else if (switchNow) begin
                pending <= 1'b0;
            end
        end
    end
endmodule

/* csp_clock_control.sv */
// Clock source decode, start-up delay timing and system clock prescaler control
`timescale 1ns/1ps
`include "csp_cfg.svh"
// Notes on behaviour
// R1: External clock: 6 CK wake; reset adds 14CK, +4 ms, +64 ms; 11 reserved.
// R2: External supplier changes frequency under 2% per cycle, else holds reset.
// R3: Source code 0010 selects RC at 4 MHz, 0100 at 8 MHz.
// R4: Divide-by-eight fuse programmed starts the system clock divided by 8.
// R5: Every reset copies the factory calibration byte into the trim register.
// R6: Reset time-out is always timed by the watchdog oscillator ticks.
// R7: Calibrated RC: 6 CK wake; reset adds 14CK plus 0, 4 or 64 ms.
// R8: Reset pin disabled with code 00 on internal oscillators stretches to 14CK+4 ms.
// R9: Code 0110 selects 128 kHz oscillator with internal start-up delays.
// R10: Upper three select bits choose the crystal band, 100 to 111.
// R11: Crystal: low select bit and start bits pick 258/1K/16K CK and reset delay.
// R12: Divider works with every source, feeding core, I/O and memory clocks.
// R13: Divider changes never produce a period shorter than old and new ones.
// R14: Divider is a counter on the undivided clock, state not observable.
// R15: New rate starts after one old period plus one to two new periods; divider switches at next old tick, first new tick one new period on.
// R16: Factor codes 0000..1000 divide by 1..256; 1001..1111 reserved.
// R17: Software writes change-enable alone, then the factor within four cycles.
// R18: Code 0000 external, 1xxx crystal, 0001/0011/0101/0111 reserved.
// R19: Count new oscillator cycles first; add watchdog-timed delay only from reset.
module csp_clock_control #(
    parameter int XTAL_SLOW_CK    = `CSP_CK_XTAL_SLOW,
    parameter int LONG_WDT_TICKS  = `CSP_DELAY_LONG_MS * `CSP_WDT_OSC_HZ / 1000,
    parameter int SHORT_WDT_TICKS = `CSP_DELAY_SHORT_MS * `CSP_WDT_OSC_HZ / 1000
) (
    input  wire logic               mclk,                    // Source clock, 250 MHz
    input  wire logic               rst_n,                   // Asynchronous reset, active low
    input  wire logic [3:0]         clockSourceSelect,       // Source select fuses
    input  wire logic [1:0]         startupTimeSelect,       // Start-up time fuses
    input  wire logic               divideByEightFuse,       // Zero means programmed
    input  wire logic               resetPinDisableFuse,     // Zero means programmed
    input  wire logic [6:0]         factoryCalibration,      // Factory trim byte
    input  wire logic               watchdogOscTick,         // Watchdog oscillator, async
    input  wire logic               powerDownRequest,        // Enter power-down, pulse
    input  wire logic               wakeRequest,             // Wake from power-down, pulse
    input  wire logic               dividerWrite,            // Divider register write strobe
    input  wire logic [7:0]         dividerWriteData,        // Divider register write data
    input  wire logic               trimWrite,               // Trim register write strobe
    input  wire logic [7:0]         trimWriteData,           // Trim register write data
    output logic                    coreClockEnable,         // Core clock enable pulse
    output logic                    ioClockEnable,           // I/O clock enable pulse
    output logic                    programMemoryClockEnable, // Program memory clock enable
    output logic                    startupDone,             // Start-up complete, level
    output logic [7:0]              oscillatorTrimRegister,  // Trim value, bit 7 zero
    output logic [7:0]              dividerRegister,         // Divider register readback
    output csp_pkg::csp_source_t    activeSource,            // Decoded source
    output logic [2:0]              crystalBandSelect,       // Crystal band, 100..111
    output logic                    clockSelectReserved,     // Reserved source code
    output logic                    startupSelectReserved    // Reserved start-up code
);
    import csp_pkg::*;

    localparam logic [15:0] CK_PD_INT   = 16'(`CSP_CK_PD_INTERNAL);
    localparam logic [15:0] CK_FAST     = 16'(`CSP_CK_XTAL_FAST);
    localparam logic [15:0] CK_MID      = 16'(`CSP_CK_XTAL_MID);
    localparam logic [15:0] CK_SLOW     = 16'(XTAL_SLOW_CK);
    localparam logic [15:0] CK_TAIL     = 16'(`CSP_CK_RESET_TAIL);
    localparam logic [15:0] TICKS_SHORT = 16'(SHORT_WDT_TICKS);
    localparam logic [15:0] TICKS_LONG  = 16'(LONG_WDT_TICKS);
    localparam logic [2:0]  WIN_LAST    = 3'(`CSP_CHANGE_WINDOW - 1);

    csp_state_t  state;
    csp_state_t  next_state;
    logic [15:0] stepCount;
    logic        fromReset;
    logic [3:0]  latchedSource;
    logic [1:0]  latchedStartup;
    logic        latchedResetPinOff;
    logic        wdtSync1;
    logic        wdtSync2;
    logic        wdtPrev;
    logic        wdtEdge;
    logic        changeEnable;
    logic [2:0]  changeTimer;
    logic        divTick;
    logic [3:0]  activeFactor;

    // Source decode from the latched fuses
    wire isCrystal  = latchedSource[`CSP_SRC_XTAL_BIT];                  // [R18]
    wire isExternal = (latchedSource == `CSP_SRC_EXTERNAL);              // [R18]
    wire isRc4      = (latchedSource == `CSP_SRC_RC_4MHZ);               // [R3]
    wire isRc8      = (latchedSource == `CSP_SRC_RC_8MHZ);               // [R3]
    wire isLp128    = (latchedSource == `CSP_SRC_LP_128KHZ);             // [R9]
    wire isInternal = isRc4 || isRc8 || isLp128;
    assign clockSelectReserved = !isCrystal && !isExternal && !isInternal; // [R18]
    assign activeSource = isCrystal ? CSP_SOURCE_CRYSTAL :
                          isExternal ? CSP_SOURCE_EXTERNAL :
                          isRc4 ? CSP_SOURCE_RC4 :
                          isRc8 ? CSP_SOURCE_RC8 :
                          isLp128 ? CSP_SOURCE_LP128 : CSP_SOURCE_RESERVED;
    assign crystalBandSelect = isCrystal ? latchedSource[3:1] : 3'h0;    // [R10]

    // Crystal delays from low select bit and start-up bits
    wire [2:0] xtalIndex = {latchedSource[0], latchedStartup};
    wire [15:0] xtalCycles = (xtalIndex <= 3'h1) ? CK_FAST :
                             (xtalIndex <= 3'h4) ? CK_MID : CK_SLOW;     // [R11]
    wire csp_rdelay_t xtalDelay =
        (xtalIndex == 3'h2 || xtalIndex == 3'h5) ? CSP_RDELAY_NONE :
        (xtalIndex == 3'h1 || xtalIndex == 3'h4 || xtalIndex == 3'h7) ? CSP_RDELAY_LONG :
        CSP_RDELAY_SHORT;                                                // [R11]

    // External and internal sources share one start-up table; reserved code
    // 11 takes the longest delay as the safe choice
    wire stretchShort = isInternal && !latchedResetPinOff;               // [R8]
    assign startupSelectReserved = !isCrystal && (latchedStartup == 2'h3); // [R1] [R7]
    wire csp_rdelay_t plainDelay =
        (latchedStartup == 2'h0) ? (stretchShort ? CSP_RDELAY_SHORT : CSP_RDELAY_NONE) :
        (latchedStartup == 2'h1) ? CSP_RDELAY_SHORT : CSP_RDELAY_LONG;   // [R1] [R7] [R9]
    wire [15:0] wakeCycles = isCrystal ? xtalCycles : CK_PD_INT;         // [R1] [R7] [R9]
    wire csp_rdelay_t resetDelay = isCrystal ? xtalDelay : plainDelay;
    wire [15:0] resetTicks = (resetDelay == CSP_RDELAY_LONG) ? TICKS_LONG : TICKS_SHORT;

    // Watchdog oscillator passes two flops before the edge detector
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wdtSync1 <= 1'b0;
            wdtSync2 <= 1'b0;
            wdtPrev  <= 1'b0;
        end else begin
            wdtSync1 <= watchdogOscTick;
            wdtSync2 <= wdtSync1;
            wdtPrev  <= wdtSync2;
        end
    end
    assign wdtEdge = wdtSync2 && !wdtPrev;

    // Sequencer transitions
    wire oscDone  = (stepCount == wakeCycles - 16'h1);
    wire tickDone = wdtEdge && (stepCount == resetTicks - 16'h1);
    wire tailDone = (stepCount == CK_TAIL - 16'h1);
    always_comb begin
        next_state = state;
        case (state)
            CSP_ST_START: next_state = CSP_ST_OSC;
            CSP_ST_OSC: begin
                // Oscillator settles first, reset time-out only after a reset
                if (oscDone) begin
                    next_state = !fromReset ? CSP_ST_RUN :
                                 (resetDelay == CSP_RDELAY_NONE) ? CSP_ST_TAIL : CSP_ST_RESET; // [R19]
                end
            end
            CSP_ST_RESET: if (tickDone) next_state = CSP_ST_TAIL;        // [R6]
            CSP_ST_TAIL:  if (tailDone) next_state = CSP_ST_RUN;         // [R1] [R7]
            CSP_ST_RUN:   if (powerDownRequest) next_state = CSP_ST_SLEEP;
            CSP_ST_SLEEP: if (wakeRequest) next_state = CSP_ST_OSC;
            default:      next_state = CSP_ST_START;
        endcase
    end

    // State, step counter and the origin of the current start-up
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state     <= CSP_ST_START;
            stepCount <= 16'h0;
            fromReset <= 1'b1;
        end else begin
            state <= next_state;
            if (next_state != state) begin
                stepCount <= 16'h0;
            end else if (state == CSP_ST_RESET) begin
                stepCount <= wdtEdge ? stepCount + 16'h1 : stepCount;   // [R6]
            end else if (state == CSP_ST_OSC || state == CSP_ST_TAIL) begin
                stepCount <= stepCount + 16'h1;                          // [R19]
            end
            if (state == CSP_ST_SLEEP) begin
                fromReset <= 1'b0;
            end
        end
    end

    // Fuses and calibration caught in the first cycle after reset release
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            latchedSource          <= `CSP_SRC_RC_8MHZ;
            latchedStartup         <= `CSP_SUT_RESET_CODE;
            latchedResetPinOff     <= 1'b1;
            oscillatorTrimRegister <= 8'h00;
        end else if (state == CSP_ST_START) begin
            latchedSource          <= clockSourceSelect;
            latchedStartup         <= startupTimeSelect;
            latchedResetPinOff     <= resetPinDisableFuse;
            oscillatorTrimRegister <= {1'b0, factoryCalibration};       // [R5]
        end else if (trimWrite) begin
            oscillatorTrimRegister <= {1'b0, trimWriteData[6:0]};
        end
    end

    // Timed change sequence; counted on the source clock
    wire unlockWrite = dividerWrite && (dividerWriteData == `CSP_DIV_CHANGE_WORD);
    wire factorWrite = dividerWrite && changeEnable
                       && !dividerWriteData[`CSP_DIV_CHANGE_BIT];        // [R17]
    wire factorOk    = factorWrite && (dividerWriteData[3:0] <= `CSP_DIV_MAX_CODE); // [R16]
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            changeEnable <= 1'b0;
            changeTimer  <= 3'h0;
        end else if (factorWrite || (changeEnable && changeTimer == WIN_LAST)) begin
            changeEnable <= 1'b0;                                        // [R17]
            changeTimer  <= 3'h0;
        end else if (changeEnable) begin
            // A repeated unlock neither extends nor cancels the window
            changeTimer <= changeTimer + 3'h1;
        end else if (unlockWrite) begin
            changeEnable <= 1'b1;
            changeTimer  <= 3'h0;
        end
    end

    csp_divider #(
        .FSEL_W (4),
        .CNT_W  (8)
    ) u_divider (
        .mclk           (mclk),
        .rst_n          (rst_n),
        .runEnable      (state == CSP_ST_RUN),
        .loadDefault    (state == CSP_ST_START),
        .defaultFactor  (divideByEightFuse ? `CSP_DIV_RESET_CODE : `CSP_DIV_BY8_CODE), // [R4]
        .newFactorValid (factorOk),                                      // [R15]
        .newFactor      (dividerWriteData[3:0]),
        .tick           (divTick),
        .activeFactor   (activeFactor)
    );

    // One divided enable drives all three synchronous domains
    assign coreClockEnable          = divTick;                           // [R12]
    assign ioClockEnable            = divTick;                           // [R12]
    assign programMemoryClockEnable = divTick;                           // [R12]
    assign startupDone              = (state == CSP_ST_RUN);
    assign dividerRegister          = {changeEnable, 3'h0, activeFactor};
endmodule

/* csp_clock_control_monitor.sv */
// Port checker for the clock source, start-up and prescaler block
`timescale 1ns/1ps
module csp_clock_control_monitor (
    input wire logic                 mclk,                     // Source clock
    input wire logic                 rst_n,                    // Reset, active low
    input wire logic                 powerDownRequest,         // Sleep request
    input wire logic                 wakeRequest,              // Wake request
    input wire logic                 dividerWrite,             // Divider write strobe
    input wire logic [7:0]           dividerWriteData,         // Divider write data
    input wire logic                 trimWrite,                // Trim write strobe
    input wire logic [7:0]           trimWriteData,            // Trim write data
    input wire logic                 coreClockEnable,          // Core tick
    input wire logic                 ioClockEnable,            // I/O tick
    input wire logic                 programMemoryClockEnable, // Memory tick
    input wire logic                 startupDone,              // Running
    input wire logic [7:0]           oscillatorTrimRegister,   // Trim value
    input wire logic [7:0]           dividerRegister,          // Divider readback
    input wire csp_pkg::csp_source_t activeSource,             // Decoded source
    input wire logic [2:0]           crystalBandSelect         // Crystal band
);
    import csp_pkg::*;
    logic [8:0] gap;
    logic [3:0] lastFac;
    logic       seen;
    wire  [3:0] minFac = (lastFac < dividerRegister[3:0]) ? lastFac : dividerRegister[3:0];

    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);

    // Spacing since last tick; forgotten while stopped so sleep gaps never count
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            gap <= 9'h0;
            seen <= 1'b0;
            lastFac <= 4'h0;
        end else if (coreClockEnable) begin
            gap <= 9'h1;
            seen <= 1'b1;
            lastFac <= dividerRegister[3:0];
        end else begin
            gap <= gap + 9'h1;
            seen <= seen & startupDone;
        end
    end

    // Wake from power-down on a non-crystal source counts six oscillator cycles, no reset delay
    sequence wakeWait;
        !startupDone [*6];
    endsequence

    chk_ticks_all_domains: assert property (
        coreClockEnable == ioClockEnable && ioClockEnable == programMemoryClockEnable)
        else $error("domain ticks differ");
    chk_tick_needs_run: assert property (coreClockEnable |-> startupDone)
        else $error("tick outside run");
    chk_no_short_period: assert property (coreClockEnable && seen |-> gap >= (9'h1 << minFac))
        else $error("divided period too short");
    chk_trim_write_load: assert property (
        trimWrite |=> oscillatorTrimRegister == ($past(trimWriteData) & 8'h7f))
        else $error("trim write wrong");
    chk_unlock_opens: assert property (
        dividerWrite && dividerWriteData == 8'h80 && !dividerRegister[7] |=> dividerRegister[7])
        else $error("change enable not set");
    chk_unlock_closes: assert property ($rose(dividerRegister[7]) |-> ##[1:4] !dividerRegister[7])
        else $error("change enable stuck");
    chk_factor_legal: assert property (dividerRegister[6:4] == 3'h0 && dividerRegister[3:0] <= 4'h8)
        else $error("divider readback illegal");
    chk_band_crystal: assert property (crystalBandSelect[2] == (activeSource == CSP_SOURCE_CRYSTAL))
        else $error("crystal band decode wrong");
    chk_done_stands: assert property (startupDone && !powerDownRequest |=> startupDone)
        else $error("run dropped");
    chk_wake_delay: assert property (
        wakeRequest && !startupDone && activeSource != CSP_SOURCE_CRYSTAL |-> wakeWait ##[0:2] startupDone)
        else $error("wake delay wrong");
endmodule

bind csp_clock_control csp_clock_control_monitor mon (.mclk, .rst_n, .powerDownRequest, .wakeRequest,
    .dividerWrite, .dividerWriteData, .trimWrite, .trimWriteData, .coreClockEnable, .ioClockEnable,
    .programMemoryClockEnable, .startupDone, .oscillatorTrimRegister, .dividerRegister, .activeSource,
    .crystalBandSelect);

/* csp_wdt_osc_model.sv */
// Free-running watchdog oscillator model for the reset time-out
`timescale 1ns/1ps
module csp_wdt_osc_model #(
    parameter real HALF_NS = 20.0 // Half period, unrelated to mclk
) (
    output logic wdtTick // Square wave to the block
);
    // Separate slow oscillator times the reset delay whatever the chip clock
    initial begin
        wdtTick = 1'b0;
        #7.3;
        forever #(HALF_NS) wdtTick = ~wdtTick;
    end
endmodule

/* csp_clock_control_bench.sv */
// Self-checking bench for the clock source, start-up and prescaler block
`timescale 1ns/1ps
module csp_clock_control_bench;
    import csp_pkg::*;
    localparam int XS = 64;
    localparam int LT = 16;
    localparam int ST = 8;
    localparam int WP = 10; // Watchdog period in mclk cycles
    logic        mclk, rst_n, divEight, rstDis, powerDown, wake, divWr, trimWr, wdtTick;
    logic        coreEn, done, clkRes, sutRes;
    logic [3:0]  srcSel;
    logic [1:0]  sutSel;
    logic [6:0]  calib;
    logic [7:0]  divData, trimData, trimReg, divReg;
    logic [2:0]  band;
    csp_source_t src;
    int          err_count = 0;
    int          cmp_count = 0;

    csp_clock_control #(.XTAL_SLOW_CK(XS), .LONG_WDT_TICKS(LT), .SHORT_WDT_TICKS(ST)) dut (
        .mclk(mclk), .rst_n(rst_n), .clockSourceSelect(srcSel), .startupTimeSelect(sutSel),
        .divideByEightFuse(divEight), .resetPinDisableFuse(rstDis), .factoryCalibration(calib),
        .watchdogOscTick(wdtTick), .powerDownRequest(powerDown), .wakeRequest(wake),
        .dividerWrite(divWr), .dividerWriteData(divData), .trimWrite(trimWr), .trimWriteData(trimData),
        .coreClockEnable(coreEn), .ioClockEnable(), .programMemoryClockEnable(), .startupDone(done),
        .oscillatorTrimRegister(trimReg), .dividerRegister(divReg), .activeSource(src),
        .crystalBandSelect(band), .clockSelectReserved(clkRes), .startupSelectReserved(sutRes));
    csp_wdt_osc_model wdt (.wdtTick(wdtTick));

    // Steady source clock; frequency never moves while running
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %0h seen %0h", name, exp, seen);
        end
    endtask

    task automatic complete_run();
        if (err_count == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Fuses only change under reset, as a real supplier must
    task automatic boot(input logic [3:0] s, input logic [1:0] t, input logic d8, input logic rd, output int cyc);
        @(posedge mclk);
        rst_n <= 1'b0;
        srcSel <= s;
        sutSel <= t;
        divEight <= d8;
        rstDis <= rd;
        calib <= {s, t, rd};
        repeat (20) @(posedge mclk);
        rst_n <= 1'b1;
        cyc = 0;
        do begin
            @(negedge mclk);
            cyc++;
        end while (done !== 1'b1 && cyc < 3000);
    endtask

    // Each source type, one reserved source code, every start-up code and every crystal combination from reset
    task automatic test_startup_table();
        logic [7:0] tbl [18] = '{8'h02, 8'h06, 8'h0a, 8'h22, 8'h20, 8'h46, 8'h60, 8'h6a, 8'h12,
                                 8'h82, 8'h86, 8'haa, 8'hce, 8'h92, 8'hb6, 8'hda, 8'hfe, 8'h4e};
        logic [3:0] s;
        logic [1:0] t;
        int cyc, n, k, i, e, tol;
        csp_source_t es;
        for (int c = 0; c < 18; c++) begin
            s = tbl[c][7:4];
            t = tbl[c][3:2];
            i = {s[0], t};
            boot(s, t, c[0], tbl[c][1], cyc);
            n = s[3] ? ((i < 2) ? 258 : (i < 5) ? 1024 : XS) : 6;
            k = (t == 2'h0) ? ((!tbl[c][1] && s != 4'h0) ? ST : 0) : (t == 2'h1) ? ST : LT;
            k = s[3] ? ((i % 3 == 2) ? 0 : (i % 3 == 0) ? ST : LT) : k;
            e = 21 + n - 6 + k * WP;
            tol = (k > 0) ? WP + 3 : 3;
            es = s[3] ? CSP_SOURCE_CRYSTAL : (s == 4'h0) ? CSP_SOURCE_EXTERNAL : (s == 4'h2) ? CSP_SOURCE_RC4 :
                 (s == 4'h4) ? CSP_SOURCE_RC8 : (s == 4'h6) ? CSP_SOURCE_LP128 : CSP_SOURCE_RESERVED;
            check("startup", (cyc >= e - tol && cyc <= e + tol), 1'b1);
            check("trim", trimReg, {1'b0, s, t, tbl[c][1]});
            check("source", src, es);
            check("band", band, s[3] ? s[3:1] : 3'h0);
            check("reserved", clkRes, s[0] & ~s[3]);
            check("sut reserved", sutRes, !s[3] && t == 2'h3);
            check("prescale", divReg, c[0] ? 8'h00 : 8'h03);
        end
    endtask

    // Power-down drops the clocks; wake needs only the oscillator count
    task automatic test_sleep();
        int cyc;
        boot(4'h4, 2'h2, 1'b0, 1'b1, cyc);
        @(posedge mclk);
        powerDown <= 1'b1;
        @(posedge mclk);
        powerDown <= 1'b0;
        repeat (2) @(posedge mclk);
        @(negedge mclk);
        check("asleep", done, 1'b0);
        @(posedge mclk);
        wake <= 1'b1;
        @(posedge mclk);
        wake <= 1'b0;
        cyc = 1;
        while (done !== 1'b1 && cyc < 100) begin
            @(negedge mclk);
            cyc++;
        end
        check("wake", (cyc >= 6 && cyc <= 9), 1'b1);
    endtask

    task automatic test_trim();
        @(posedge mclk);
        trimWr <= 1'b1;
        trimData <= 8'hff;
        @(posedge mclk);
        trimWr <= 1'b0;
        @(negedge mclk);
        check("trim write", trimReg, 8'h7f);
    endtask

    // Unlock alone, then the factor write after gap idle cycles
    task automatic set_factor(input logic [7:0] v, input int gap);
        @(posedge mclk);
        divWr <= 1'b1;
        divData <= 8'h80;
        @(posedge mclk);
        divWr <= 1'b0;
        repeat (gap) @(posedge mclk);
        divWr <= 1'b1;
        divData <= v;
        @(posedge mclk);
        divWr <= 1'b0;
    endtask

    task automatic measure(output int p);
        int w;
        w = 0;
        do begin
            @(negedge mclk);
            w++;
        end while (coreEn !== 1'b1 && w < 600);
        p = 0;
        do begin
            @(negedge mclk);
            p++;
        end while (coreEn !== 1'b1 && p < 600);
    endtask

    // All factors in turn, then writes that must be refused
    task automatic test_divider();
        int p;
        boot(4'h0, 2'h0, 1'b1, 1'b1, p);
        for (int f = 0; f < 9; f++) begin
            set_factor(8'(f), 1);
            measure(p);
            measure(p);
            check("period", p, 1 << f);
            check("factor", divReg, 8'(f));
        end
        set_factor(8'h09, 1);
        @(posedge mclk);
        divWr <= 1'b1;
        divData <= 8'h05;
        @(posedge mclk);
        divWr <= 1'b0;
        set_factor(8'h01, 5);
        @(negedge mclk);
        check("refused", divReg, 8'h08);
    endtask

    // Hang guard sized well above the expected run
    initial begin
        #100000;
        err_count++;
        complete_run();
    end

    initial begin
        rst_n = 1'b0;
        srcSel = 4'h4;
        sutSel = 2'h2;
        divEight = 1'b0;
        rstDis = 1'b1;
        calib = 7'h00;
        powerDown = 1'b0;
        wake = 1'b0;
        divWr = 1'b0;
        divData = 8'h00;
        trimWr = 1'b0;
        trimData = 8'h00;
        test_startup_table();
        test_sleep();
        test_trim();
        test_divider();
        complete_run();
    end
endmodule
